/* core/cbseq_pkg.sv */
// types and constants of the bus cycle sequencer
// assumes one clock; instruction kind and conditions come from the decoder on that clock
package cbseq_pkg;

  // instruction groups that have their own machine cycle pattern
  typedef enum logic [3:0] {
    INS_CMP_SINGLE,      // compare with pointer step, once
    INS_CMP_REPEAT,      // compare_increment_repeat / compare_decrement_repeat
    INS_COMPLEMENT,      // accumulator complement
    INS_DEC_ADJUST,      // decimal adjust
    INS_INT_DISABLE,     // interrupt_disable_instr
    INS_DEC_BRANCH,      // decrement_branch_nonzero
    INS_INT_ENABLE,      // interrupt_enable_instr
    INS_EXCH_REG,        // register pair exchange, one fetch
    INS_EXCH_ALT,        // alternate accumulator exchange
    INS_EXCH_STACK,      // exchange top of stack with pair
    INS_EXCH_STACK_IDX,  // exchange top of stack with index register
    INS_HALT,            // halt
    INS_INT_MODE,        // interrupt mode setting
    INS_INC_REG,         // increment or decrement of a register
    INS_INC_MEM          // increment or decrement of memory
  } cbseq_instr_type;

  // kind of one machine cycle
  typedef enum logic [2:0] {
    CYC_OF1,  // first opcode fetch
    CYC_OF2,  // second opcode fetch
    CYC_RD,   // memory read
    CYC_WR,   // memory write
    CYC_INT,  // internal_state, one clock
    CYC_END   // past the last cycle
  } cbseq_cycle_type;

  typedef cbseq_cycle_type [0:7] cbseq_seq_type;

  // strobe levels of one cycle, all toward the pins
  typedef struct packed {
    logic rd_n;     // read_strobe_n
    logic wr_n;     // write_strobe_n
    logic mem_request_n_n;   // mem_request_n
    logic io_request_n_n;   // io_request_n
    logic fetch_n;  // opcode_fetch_cycle_n
    logic halt_n;   // halt
    logic status;   // status_line
    logic data_oe;  // data bus driven
  } cbseq_strobe_type;

  localparam int unsigned IDX_W = 4;
  localparam logic [IDX_W-1:0] IDX_LAST_SLOT = 4'h7;
  // loop branch refuses bus requests from the boundary that closes its internal state
  localparam logic [IDX_W-1:0] IDX_BRANCH_BLOCK = 4'h1;
  localparam logic [1:0] TSTATE_FIRST = 2'h0;
  localparam logic [1:0] TSTATE_LAST = 2'h2;
  localparam cbseq_strobe_type STB_INTERNAL = 8'hFE;
  localparam cbseq_strobe_type STB_FETCH_FIRST = 8'h54;
  localparam cbseq_strobe_type STB_FETCH_NEXT = 8'h56;
  localparam cbseq_strobe_type STB_MEM_READ = 8'h5E;
  localparam cbseq_strobe_type STB_MEM_WRITE = 8'h9F;
  localparam cbseq_strobe_type STB_HALT_FETCH = 8'h50;
  localparam cbseq_strobe_type STB_RESET = 8'hFE;

endpackage

/* core/cbseq_sequencer.sv */
// machine cycle sequencer: walks each instruction's cycles and drives the control strobes
// assumes the decoder presents instruction kind and loop conditions on MCLK;
// interrupt and bus requests arrive asynchronously from pins
`timescale 1ns/1ns

// Contract
// RL1: first fetch: read, memory, fetch, status low
// RL2: internal state: strobes high, bus released
// RL3: no interrupt sample after disable/enable
// RL4: loop branch ignores bus requests late
// RL5: loop branch adds two internals when nonzero
// RL6: repeat compare: five internals else three
// RL7: halted: repeat fetches with halt low
module cbseq_sequencer
  import cbseq_pkg::*;
(
  input  wire logic            MCLK,
  input  wire logic            RSTN,
  input  wire logic            INSTR_VALID,
  input  wire cbseq_instr_type INSTR_KIND,
  input  wire logic            LOOP_NONZERO,
  input  wire logic            COUNT_NONZERO,
  input  wire logic            MATCH_FOUND,
  input  wire logic            HALT_EXIT,
  input  wire logic            INT_REQ,
  input  wire logic            DMA_REQ,
  input  wire logic            REFRESH_REQ,
  input  wire logic            RELEASE_REQ,
  output logic                 INSTR_READY,
  output logic                 READ_STROBE_N,
  output logic                 WRITE_STROBE_N,
  output logic                 MEM_REQUEST_N,
  output logic                 IO_REQUEST_N,
  output logic                 OPCODE_FETCH_CYCLE_N,
  output logic                 HALT_N,
  output logic                 STATUS_LINE,
  output logic                 DATA_OE,
  output logic                 INT_SAMPLE,
  output logic                 BUS_GRANT
);

  typedef enum logic [1:0] {MODE_IDLE, MODE_RUN, MODE_HALTED} cbseq_mode_type;

  // cycle pattern of an instruction; go selects the longer branch of conditional ones
  function automatic cbseq_cycle_type seq_kind(input cbseq_instr_type ins, input logic [IDX_W-1:0] idx,
                                               input logic go);
    cbseq_seq_type s;
    s = '{CYC_OF1, CYC_END, CYC_END, CYC_END, CYC_END, CYC_END, CYC_END, CYC_END};
    unique case (ins)
      INS_CMP_SINGLE:     s = '{CYC_OF1, CYC_OF2, CYC_RD, CYC_INT, CYC_INT, CYC_INT, CYC_END, CYC_END};
      // RL6: repeat compare length
      INS_CMP_REPEAT: begin
        // patterns kept out of a conditional operator, where they would have no target type
        if (go) begin
          s = '{CYC_OF1, CYC_OF2, CYC_RD, CYC_INT, CYC_INT, CYC_INT, CYC_INT, CYC_INT};
        end else begin
          s = '{CYC_OF1, CYC_OF2, CYC_RD, CYC_INT, CYC_INT, CYC_INT, CYC_END, CYC_END};
        end
      end
      INS_COMPLEMENT,
      INS_INT_DISABLE,
      INS_INT_ENABLE,
      INS_EXCH_REG,
      INS_HALT:           s = '{CYC_OF1, CYC_END, CYC_END, CYC_END, CYC_END, CYC_END, CYC_END, CYC_END};
      INS_DEC_ADJUST,
      INS_EXCH_ALT,
      INS_INC_REG:        s = '{CYC_OF1, CYC_INT, CYC_END, CYC_END, CYC_END, CYC_END, CYC_END, CYC_END};
      // RL5: loop branch length
      INS_DEC_BRANCH: begin
        if (go) begin
          s = '{CYC_OF1, CYC_INT, CYC_RD, CYC_INT, CYC_INT, CYC_END, CYC_END, CYC_END};
        end else begin
          s = '{CYC_OF1, CYC_INT, CYC_RD, CYC_END, CYC_END, CYC_END, CYC_END, CYC_END};
        end
      end
      INS_EXCH_STACK:     s = '{CYC_OF1, CYC_RD, CYC_RD, CYC_INT, CYC_WR, CYC_WR, CYC_END, CYC_END};
      INS_EXCH_STACK_IDX: s = '{CYC_OF1, CYC_OF2, CYC_RD, CYC_RD, CYC_INT, CYC_WR, CYC_WR, CYC_END};
      INS_INT_MODE:       s = '{CYC_OF1, CYC_OF2, CYC_END, CYC_END, CYC_END, CYC_END, CYC_END, CYC_END};
      INS_INC_MEM:        s = '{CYC_OF1, CYC_RD, CYC_INT, CYC_WR, CYC_END, CYC_END, CYC_END, CYC_END};
      default:            s = '{CYC_OF1, CYC_END, CYC_END, CYC_END, CYC_END, CYC_END, CYC_END, CYC_END};
    endcase
    // slot nine only exists for the long repeat compare, and it is the end
    seq_kind = (idx > IDX_LAST_SLOT) ? CYC_END : s[idx[2:0]];
  endfunction

  // strobe levels of a cycle kind
  function automatic cbseq_strobe_type strobe_of(input cbseq_cycle_type k);
    unique case (k)
      // RL1: first fetch levels
      CYC_OF1: strobe_of = STB_FETCH_FIRST;
      CYC_OF2: strobe_of = STB_FETCH_NEXT;
      CYC_RD:  strobe_of = STB_MEM_READ;
      CYC_WR:  strobe_of = STB_MEM_WRITE;
      // RL2: internal state idle levels
      default: strobe_of = STB_INTERNAL;
    endcase
  endfunction

  // state
  cbseq_mode_type   mode_reg;       // idle, running or halted
  cbseq_instr_type  instr_reg;      // instruction being run
  logic             go_reg;         // longer branch chosen at accept
  logic [IDX_W-1:0] idx_reg;        // machine cycle index
  logic [1:0]       tstate_reg;     // T1..T3 within a bus cycle
  cbseq_strobe_type strobe_reg;     // registered pin levels
  logic             ready_reg;      // accepting an instruction
  logic             int_sample_reg; // interrupt taken at boundary
  logic             grant_reg;      // bus request granted at boundary

  // two-stage synchronisers for the pin requests
  logic [3:0] req_meta_reg;         // first stage, read only by second
  logic [3:0] req_sync_reg;         // {int, dma, refresh, release}

  // next values
  cbseq_mode_type   mode_next;
  cbseq_instr_type  instr_next;
  logic             go_next;
  logic [IDX_W-1:0] idx_next;
  logic [1:0]       tstate_next;

  // current cycle decode
  wire cbseq_cycle_type cur_kind = seq_kind(instr_reg, idx_reg, go_reg);
  wire logic cyc_last = (cur_kind == CYC_INT) || (tstate_reg == TSTATE_LAST);
  wire logic [IDX_W-1:0] idx_inc = idx_reg + 4'h1;
  wire logic instr_end = (mode_reg == MODE_RUN) && cyc_last && (seq_kind(instr_reg, idx_inc, go_reg) == CYC_END);
  wire logic halt_cyc_end = (mode_reg == MODE_HALTED) && (tstate_reg == TSTATE_LAST);
  // repeat compare continues only while counting and unmatched
  wire logic accept_go = (INSTR_KIND == INS_CMP_REPEAT) ? (COUNT_NONZERO && !MATCH_FOUND) : LOOP_NONZERO;
  wire cbseq_cycle_type next_kind = seq_kind(instr_next, idx_next, go_next);

  // RL3: disable/enable never sample
  wire logic no_sample = (instr_reg == INS_INT_DISABLE) || (instr_reg == INS_INT_ENABLE);
  wire logic int_sample_next = req_sync_reg[3] && ((instr_end && !no_sample) || halt_cyc_end);

  // RL4: blocked after branch internal
  wire logic bus_blocked = (mode_reg == MODE_RUN) && (instr_reg == INS_DEC_BRANCH) && (idx_reg >= IDX_BRANCH_BLOCK);
  wire logic boundary = (mode_reg == MODE_IDLE) || ((mode_reg == MODE_RUN) && cyc_last) || halt_cyc_end;
  wire logic grant_next = (|req_sync_reg[2:0]) && boundary && !bus_blocked && !int_sample_next;

  // next state of the sequencer
  always_comb begin
    mode_next   = mode_reg;
    instr_next  = instr_reg;
    go_next     = go_reg;
    idx_next    = idx_reg;
    tstate_next = tstate_reg;
    unique case (mode_reg)
      MODE_IDLE: begin
        // take a new instruction only while idle
        if (INSTR_VALID) begin
          mode_next   = MODE_RUN;
          instr_next  = INSTR_KIND;
          go_next     = accept_go;
          idx_next    = '0;
          tstate_next = TSTATE_FIRST;
        end
      end
      MODE_RUN: begin
        if (cyc_last) begin
          idx_next    = idx_inc;
          tstate_next = TSTATE_FIRST;
          // RL7: halt enters repeated fetches
          if (instr_end) begin
            mode_next = (instr_reg == INS_HALT) ? MODE_HALTED : MODE_IDLE;
          end
        end else begin
          tstate_next = tstate_reg + 2'h1;
        end
      end
      MODE_HALTED: begin
        // RL7: fetch cycles repeat until exit
        if (tstate_reg == TSTATE_LAST) begin
          tstate_next = TSTATE_FIRST;
          if (HALT_EXIT) begin
            mode_next = MODE_IDLE;
          end
        end else begin
          tstate_next = tstate_reg + 2'h1;
        end
      end
      default: mode_next = MODE_IDLE;
    endcase
  end

  // pin levels for the coming clock, so every output leaves a flop
  wire cbseq_strobe_type strobe_next = (mode_next == MODE_RUN)    ? strobe_of(next_kind) :
                                       (mode_next == MODE_HALTED) ? STB_HALT_FETCH : STB_INTERNAL;

  // synchronisers
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      req_meta_reg <= 4'h0;
      req_sync_reg <= 4'h0;
    end else begin
      req_meta_reg <= {INT_REQ, DMA_REQ, REFRESH_REQ, RELEASE_REQ};
      req_sync_reg <= req_meta_reg;
    end
  end

  // sequencer state
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      mode_reg   <= MODE_IDLE;
      instr_reg  <= INS_COMPLEMENT;
      go_reg     <= 1'b0;
      idx_reg    <= '0;
      tstate_reg <= TSTATE_FIRST;
    end else begin
      mode_reg   <= mode_next;
      instr_reg  <= instr_next;
      go_reg     <= go_next;
      idx_reg    <= idx_next;
      tstate_reg <= tstate_next;
    end
  end

  // output flops
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      strobe_reg     <= STB_RESET;
      ready_reg      <= 1'b1;
      int_sample_reg <= 1'b0;
      grant_reg      <= 1'b0;
    end else begin
      strobe_reg     <= strobe_next;
      ready_reg      <= (mode_next == MODE_IDLE);
      int_sample_reg <= int_sample_next;
      grant_reg      <= grant_next;
    end
  end

  assign INSTR_READY          = ready_reg;
  assign READ_STROBE_N        = strobe_reg.rd_n;
  assign WRITE_STROBE_N       = strobe_reg.wr_n;
  assign MEM_REQUEST_N        = strobe_reg.mem_request_n_n;
  assign IO_REQUEST_N         = strobe_reg.io_request_n_n;
  assign OPCODE_FETCH_CYCLE_N = strobe_reg.fetch_n;
  assign HALT_N               = strobe_reg.halt_n;
  assign STATUS_LINE          = strobe_reg.status;
  assign DATA_OE              = strobe_reg.data_oe;
  assign INT_SAMPLE           = int_sample_reg;
  assign BUS_GRANT            = grant_reg;

endmodule // cbseq_sequencer

/* bench/cbseq_bus_partner.sv */
// bus partner: memory as seen from the strobes
// assumes registered strobe levels on the sequencer clock
`timescale 1ns/1ns
module cbseq_bus_partner (
  input  wire logic clk,
  input  wire logic rd_n,
  input  wire logic wr_n,
  input  wire logic mem_request_n_n,
  input  wire logic oe,
  output logic      clash
);
  logic mem_drive;  // memory owns the data lines
  // memory answers a selected read at once, so a core driving then is a fight
  assign mem_drive = !rd_n && !mem_request_n_n;
  // read and write strobes together are never legal
  always_ff @(posedge clk) begin
    clash <= (mem_drive && oe) || (!rd_n && !wr_n);
  end
endmodule // cbseq_bus_partner

/* bench/cbseq_sequencer_assertions.sv */
// checker: machine cycle patterns and strobe levels
// assumes it is bound to cbseq_sequencer and sees only its ports
`timescale 1ns/1ns
module cbseq_sequencer_chk
  import cbseq_pkg::*;
(
  input wire logic            MCLK,
  input wire logic            RSTN,
  input wire logic            INSTR_VALID,
  input wire cbseq_instr_type INSTR_KIND,
  input wire logic            LOOP_NONZERO,
  input wire logic            COUNT_NONZERO,
  input wire logic            MATCH_FOUND,
  input wire logic            INSTR_READY,
  input wire logic            READ_STROBE_N,
  input wire logic            WRITE_STROBE_N,
  input wire logic            MEM_REQUEST_N,
  input wire logic            IO_REQUEST_N,
  input wire logic            OPCODE_FETCH_CYCLE_N,
  input wire logic            HALT_N,
  input wire logic            STATUS_LINE,
  input wire logic            DATA_OE,
  input wire logic            INT_SAMPLE,
  input wire logic            BUS_GRANT
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  wire take = INSTR_VALID && INSTR_READY;  // instruction accepted
  wire go = COUNT_NONZERO && !MATCH_FOUND;  // repeat goes on
  // one cycle shapes, three clocks each for bus cycles, one clock for internal
  sequence s_fetch;
    (!READ_STROBE_N && WRITE_STROBE_N && !MEM_REQUEST_N && IO_REQUEST_N && !OPCODE_FETCH_CYCLE_N && HALT_N
      && !STATUS_LINE)[*3];
  endsequence
  sequence s_next;
    (!OPCODE_FETCH_CYCLE_N && STATUS_LINE && !MEM_REQUEST_N)[*3];
  endsequence
  sequence s_read;
    (!READ_STROBE_N && !MEM_REQUEST_N && OPCODE_FETCH_CYCLE_N && STATUS_LINE)[*3];
  endsequence
  sequence s_int;
    MEM_REQUEST_N && STATUS_LINE;
  endsequence
  fetch_first_a: assert property (take |=> s_fetch)
    else $error("first fetch levels wrong");
  int_quiet_a: assert property (MEM_REQUEST_N && IO_REQUEST_N |-> READ_STROBE_N && WRITE_STROBE_N
    && !DATA_OE && STATUS_LINE && OPCODE_FETCH_CYCLE_N && HALT_N) else $error("strobe active while internal");
  int_skip_a: assert property (take && INSTR_KIND inside {INS_INT_DISABLE, INS_INT_ENABLE}
    |=> !INT_SAMPLE[*5]) else $error("interrupt sampled after enable or disable");
  branch_grant_a: assert property (take && INSTR_KIND == INS_DEC_BRANCH |=> ##4 !BUS_GRANT[*4])
    else $error("bus granted late in loop branch");
  branch_taken_a: assert property (take && INSTR_KIND == INS_DEC_BRANCH && LOOP_NONZERO
    |=> s_fetch ##1 s_int ##1 s_read ##1 s_int[*2] ##1 INSTR_READY) else $error("taken branch pattern wrong");
  branch_done_a: assert property (take && INSTR_KIND == INS_DEC_BRANCH && !LOOP_NONZERO
    |=> s_fetch ##1 s_int ##1 s_read ##1 INSTR_READY) else $error("final branch pattern wrong");
  repeat_go_a: assert property (take && INSTR_KIND == INS_CMP_REPEAT && go
    |=> s_fetch ##1 s_next ##1 s_read ##1 s_int[*5] ##1 INSTR_READY) else $error("repeat tail not five");
  repeat_stop_a: assert property (take && INSTR_KIND == INS_CMP_REPEAT && !go
    |=> s_fetch ##1 s_next ##1 s_read ##1 s_int[*3] ##1 INSTR_READY) else $error("stop tail not three");
  halt_entry_a: assert property (take && INSTR_KIND == INS_HALT |=> s_fetch ##1 !HALT_N[*3])
    else $error("halt fetch did not follow");
  halt_levels_a: assert property (!HALT_N |-> !OPCODE_FETCH_CYCLE_N && !STATUS_LINE && !MEM_REQUEST_N)
    else $error("halt fetch levels wrong");
endmodule // cbseq_sequencer_chk

bind cbseq_sequencer cbseq_sequencer_chk i_chk (.*);

/* bench/testbench.sv */
// bench: each instruction kind per clock, then a random mix
// assumes package, sequencer, checker and partner compiled first
`timescale 1ns/1ns
module testbench
  import cbseq_pkg::*;
;
  logic            MCLK, RSTN, INSTR_VALID, LOOP_NONZERO, COUNT_NONZERO, MATCH_FOUND, HALT_EXIT;
  logic            INT_REQ, DMA_REQ, REFRESH_REQ, RELEASE_REQ, INSTR_READY, READ_STROBE_N;
  logic            WRITE_STROBE_N, MEM_REQUEST_N, IO_REQUEST_N, OPCODE_FETCH_CYCLE_N, HALT_N;
  logic            STATUS_LINE, DATA_OE, INT_SAMPLE, BUS_GRANT, clash;
  cbseq_instr_type INSTR_KIND;
  int              n_fail, samples_checked;
  logic [7:0]      exp_q[$];  // {rd,wr,mem_request_n,io_request_n,fetch,halt,status,oe} per clock
  cbseq_sequencer i_dut (.*);
  cbseq_bus_partner i_mem (.clk(MCLK), .rd_n(READ_STROBE_N), .wr_n(WRITE_STROBE_N), .mem_request_n_n(MEM_REQUEST_N),
    .oe(DATA_OE), .clash(clash));
  always #2 MCLK = ~MCLK;
  task automatic results();
    if (n_fail == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] e, input logic [7:0] a);
    samples_checked++;
    if (e !== a) begin
      n_fail++;
      $display("Error at %0t: expected %h got %h", $time, e, a);
    end
  endtask
  task automatic add(input logic [7:0] s, input int n);
    repeat (n) exp_q.push_back(s);
  endtask
  // expected bytes: fetch 54, next fetch 56, read 5E, write 9F, internal FE, halt 50
  task automatic plan(input cbseq_instr_type k, input logic lnz, input logic go);
    exp_q.delete();
    add(8'h54, 3);
    case (k)
      INS_CMP_SINGLE, INS_CMP_REPEAT: begin
        add(8'h56, 3);
        add(8'h5E, 3);
        add(8'hFE, (k == INS_CMP_REPEAT && go) ? 5 : 3);
      end
      INS_DEC_ADJUST, INS_EXCH_ALT, INS_INC_REG: add(8'hFE, 1);
      INS_DEC_BRANCH: begin
        add(8'hFE, 1);
        add(8'h5E, 3);
        add(8'hFE, lnz ? 2 : 0);
      end
      INS_EXCH_STACK, INS_EXCH_STACK_IDX, INS_INC_MEM: begin
        if (k == INS_EXCH_STACK_IDX) add(8'h56, 3);
        add(8'h5E, (k == INS_INC_MEM) ? 3 : 6);
        add(8'hFE, 1);
        add(8'h9F, (k == INS_INC_MEM) ? 3 : 6);
      end
      INS_INT_MODE: add(8'h56, 3);
      INS_HALT: add(8'h50, 6);
      default: ;
    endcase
  endtask
  // interrupt pulse expected at clock i of a run that lasts n clocks
  function automatic logic int_expect(input cbseq_instr_type k, input int i, input int n, input logic irq);
    if (k inside {INS_INT_DISABLE, INS_INT_ENABLE}) return 1'b0;
    if (i == n) return irq;
    // halt also samples at the end of its opcode fetch and of its first halt fetch
    return irq && k == INS_HALT && (i == 3 || i == 6);
  endfunction
  // one instruction, checked clock by clock up to its idle clock
  task automatic run(input cbseq_instr_type k, input logic lnz, input logic cz, input logic mf,
                     input logic [3:0] req);
    int i;
    plan(k, lnz, cz && !mf);
    {INT_REQ, DMA_REQ, REFRESH_REQ, RELEASE_REQ} = req;
    {INSTR_KIND, LOOP_NONZERO, COUNT_NONZERO, MATCH_FOUND} = {k, lnz, cz, mf};
    INSTR_VALID = 1'b1;
    for (i = 0; i < 40 && INSTR_READY !== 1'b1; i++) @(negedge MCLK);
    @(negedge MCLK);
    INSTR_VALID = 1'b0;
    for (i = 0; i <= exp_q.size(); i++) begin
      // leave halt only late in the second halt fetch
      HALT_EXIT = k == INS_HALT && i + 2 >= exp_q.size() && i < exp_q.size();
      chk((i < exp_q.size()) ? exp_q[i] : 8'hFE, {READ_STROBE_N, WRITE_STROBE_N, MEM_REQUEST_N,
        IO_REQUEST_N, OPCODE_FETCH_CYCLE_N, HALT_N, STATUS_LINE, DATA_OE});
      chk({7'h00, i == exp_q.size()}, {7'h00, INSTR_READY});
      chk(8'h00, {7'h00, clash});
      chk({7'h00, int_expect(k, i, exp_q.size(), req[3])}, {7'h00, INT_SAMPLE});
      if (k == INS_DEC_BRANCH && i >= 3 && req[2:0] != 3'h0) chk({7'h00, i < 4}, {7'h00, BUS_GRANT});
      // other kinds grant at their last boundary unless the interrupt wins it
      if (k != INS_DEC_BRANCH && i == exp_q.size())
        chk({7'h00, req[2:0] != 3'h0 && !int_expect(k, i, exp_q.size(), req[3])}, {7'h00, BUS_GRANT});
      @(negedge MCLK);
    end
  endtask
  initial begin
    {MCLK, RSTN, INSTR_VALID, LOOP_NONZERO, COUNT_NONZERO, MATCH_FOUND, HALT_EXIT} = 7'h00;
    {INT_REQ, DMA_REQ, REFRESH_REQ, RELEASE_REQ} = 4'h0;
    INSTR_KIND = INS_CMP_SINGLE;
    n_fail = 0;
    samples_checked = 0;
    void'($urandom(32'hA9EB));
    repeat (8) @(negedge MCLK);
    RSTN = 1'b1;
    // every kind; branch and repeat both ways, requests held
    for (int k = 0; k < 15; k++) begin
      run(cbseq_instr_type'(k), 1'b1, 1'b1, 1'b0, 4'hF);
      run(cbseq_instr_type'(k), 1'b0, 1'b0, 1'b0, 4'h0);
      run(cbseq_instr_type'(k), 1'b0, 1'b1, 1'b1, 4'h5);
    end
    // random kinds, conditions and requests
    repeat (60) run(cbseq_instr_type'($urandom_range(14)), 1'($urandom), 1'($urandom), 1'($urandom), 4'($urandom));
    results();
  end
  // hang guard: the runs need about a thousand clocks
  initial begin
    #80000;
    n_fail++;
    results();
  end
endmodule // testbench
